// ---- ipa_pkg.sv ----
// constants and types of the indirect pointer addressing unit
package ipa_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int PTR_W = 16;
   // virtual register block per pointer: plain, post_decrement_access, post_increment_access, pre_increment_access, accumulator_offset_access
   localparam logic [11:0] VIRT_BASE_0 = 12'hFEB;
   localparam logic [11:0] VIRT_BASE_1 = 12'hFE3;
   localparam logic [11:0] VIRT_BASE_2 = 12'hFDB;
   localparam logic [11:0] PTR_BASE_0 = 12'hFE9;
   localparam logic [11:0] PTR_BASE_1 = 12'hFE1;
   localparam logic [11:0] PTR_BASE_2 = 12'hFD9;
   localparam logic [7:0] OFFSET_LIMIT = 8'h5F;
   localparam logic [7:0] QUICK_SPLIT = 8'h60;
   localparam logic [11:0] QUICK_HIGH_BASE = 12'hF00;
   localparam logic [7:0] READ_ZERO = 8'h00;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam logic [15:0] PTR_ONE = 16'h0001;

   typedef enum logic [2:0]
   {
      IPA_PLAIN = 3'h0,
      IPA_POST_DECREMENT_ACCESS = 3'h1,
      IPA_POST_INCREMENT_ACCESS = 3'h2,
      IPA_PRE_INCREMENT_ACCESS = 3'h3,
      IPA_ACCUMULATOR_OFFSET_ACCESS = 3'h4
   } ipa_mode_t;

   typedef enum logic [1:0]
   {
      IPA_IDLE = 2'h0,
      IPA_RESOLVE = 2'h1,
      IPA_ACCESS = 2'h2
   } ipa_state_t;
endpackage : ipa_pkg

// ---- ipa_indirect_unit.sv ----
// indirect pointer addressing unit: pointer pairs, virtual registers, indexed offset
`timescale 1ns/1ps
`default_nettype none
module ipa_indirect_unit
   import ipa_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic extended_set_enable_bit_i,
   // request from execution unit: one-cycle pulse
   input wire logic req_i,
   input wire logic req_write_i,
   input wire logic req_direct_i,
   input wire logic req_access_bank_i,
   input wire logic [ADDR_W-1:0] req_addr_i,
   input wire logic [DATA_W-1:0] req_wdata_i,
   input wire logic [DATA_W-1:0] acc_i,
   // data memory port
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic [DATA_W-1:0] mem_wdata_o,
   input wire logic [DATA_W-1:0] mem_rdata_i,
   // answer
   output logic done_o,
   output logic [DATA_W-1:0] rdata_o,
   output logic [PTR_W-1:0] ptr0_o,
   output logic [PTR_W-1:0] ptr1_o,
   output logic [PTR_W-1:0] ptr2_o
);
   // ==================================================
   // decode helpers
   // ==================================================
   // which pointer owns a virtual register address, 3 = none
   function automatic logic [1:0] virt_ptr(input logic [ADDR_W-1:0] a);
      if (a >= VIRT_BASE_0 && a <= VIRT_BASE_0 + 12'h004)
         virt_ptr = 2'h0;
      else if (a >= VIRT_BASE_1 && a <= VIRT_BASE_1 + 12'h004)
         virt_ptr = 2'h1;
      else if (a >= VIRT_BASE_2 && a <= VIRT_BASE_2 + 12'h004)
         virt_ptr = 2'h2;
      else
         virt_ptr = 2'h3;
   endfunction : virt_ptr

   function automatic ipa_mode_t virt_mode(input logic [ADDR_W-1:0] a, input logic [1:0] p);
      logic [ADDR_W-1:0] base;
      base = (p == 2'h0) ? VIRT_BASE_0 : (p == 2'h1) ? VIRT_BASE_1 : VIRT_BASE_2;
      // plain at base+4, then post_decrement_access, post_increment_access, pre_increment_access, accumulator_offset_access downward order
      case (a - base)
         12'h004: virt_mode = IPA_PLAIN;
         12'h003: virt_mode = IPA_POST_DECREMENT_ACCESS;
         12'h002: virt_mode = IPA_POST_INCREMENT_ACCESS;
         12'h001: virt_mode = IPA_PRE_INCREMENT_ACCESS;
         default: virt_mode = IPA_ACCUMULATOR_OFFSET_ACCESS;
      endcase
   endfunction : virt_mode

   // pointer pair register byte: 0=low,1=high of pointer p, else none
   function automatic logic [2:0] ptr_byte(input logic [ADDR_W-1:0] a);
      if (a == PTR_BASE_0) ptr_byte = 3'h0;
      else if (a == PTR_BASE_0 + 12'h001) ptr_byte = 3'h1;
      else if (a == PTR_BASE_1) ptr_byte = 3'h2;
      else if (a == PTR_BASE_1 + 12'h001) ptr_byte = 3'h3;
      else if (a == PTR_BASE_2) ptr_byte = 3'h4;
      else if (a == PTR_BASE_2 + 12'h001) ptr_byte = 3'h5;
      else ptr_byte = 3'h7;
   endfunction : ptr_byte

   // ==================================================
   // state
   // ==================================================
   logic [PTR_W-1:0] ptr_r [3];
   ipa_state_t state_r;
   logic we_r;
   logic [ADDR_W-1:0] tgt_r;
   logic [DATA_W-1:0] wd_r;

   // ==================================================
   // request resolution
   // ==================================================
   logic [1:0] vp;
   ipa_mode_t vm;
   logic [PTR_W-1:0] cur;
   logic [PTR_W-1:0] eff;
   logic [PTR_W-1:0] upd;
   logic do_upd;
   logic [ADDR_W-1:0] tgt_nxt;
   logic xmode;
   logic [2:0] pb;

   always_comb
   begin
      vp = virt_ptr(req_addr_i);
      vm = virt_mode(req_addr_i, vp);
      cur = (vp == 2'h3) ? PTR_RESET : ptr_r[vp];
      eff = cur;
      upd = cur;
      do_upd = 1'b0;
      xmode = extended_set_enable_bit_i == 1'b1;
      case (vm)
         IPA_POST_DECREMENT_ACCESS:
         begin
            upd = cur - PTR_ONE;
            do_upd = 1'b1;
         end
         IPA_POST_INCREMENT_ACCESS:
         begin
            upd = cur + PTR_ONE;
            do_upd = 1'b1;
         end
         IPA_PRE_INCREMENT_ACCESS:
         begin
            upd = cur + PTR_ONE;
            eff = upd;
            do_upd = 1'b1;
         end
         IPA_ACCUMULATOR_OFFSET_ACCESS:
            eff = cur + {8'h00, acc_i};
         default:
            eff = cur;
      endcase
      if (req_direct_i)
      begin
         if (xmode && req_access_bank_i && req_addr_i[7:0] <= OFFSET_LIMIT)
            tgt_nxt = ADDR_W'(ptr_r[2] + {8'h00, req_addr_i[7:0]});
         else if (req_access_bank_i)
            tgt_nxt = (req_addr_i[7:0] >= QUICK_SPLIT) ?
               (QUICK_HIGH_BASE | {4'h0, req_addr_i[7:0]}) : {4'h0, req_addr_i[7:0]};
         else
            tgt_nxt = req_addr_i;
         do_upd = 1'b0;
      end
      else if (vp == 2'h3)
      begin
         tgt_nxt = req_addr_i;
         do_upd = 1'b0;
      end
      else
         tgt_nxt = eff[ADDR_W-1:0];
      pb = ptr_byte(tgt_nxt);
   end

   // ==================================================
   // sequencing: resolve in the request cycle, one access cycle, answer on the cycle after
   // ==================================================
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_r <= IPA_IDLE;
         we_r <= 1'b0;
         tgt_r <= '0;
         wd_r <= '0;
      end
      else
      begin
         case (state_r)
            IPA_IDLE:
               if (req_i)
               begin
                  state_r <= IPA_ACCESS;
                  we_r <= req_write_i;
                  tgt_r <= tgt_nxt;
                  wd_r <= req_wdata_i;
               end
            IPA_ACCESS:
               state_r <= IPA_IDLE;
            default:
               state_r <= IPA_IDLE;
         endcase
      end
   end

   // pointer pairs; status flags are not in this block at all, so never altered
   logic ind_req;
   logic tgt_virt_r;
   logic [2:0] tpb_r;
   assign ind_req = req_i && (state_r == IPA_IDLE) && !req_direct_i && (vp != 2'h3);

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ptr_r[0] <= PTR_RESET;
         ptr_r[1] <= PTR_RESET;
         ptr_r[2] <= PTR_RESET;
         tgt_virt_r <= 1'b0;
         tpb_r <= 3'h7;
      end
      else
      begin
         if (req_i && state_r == IPA_IDLE)
         begin
            tgt_virt_r <= !req_direct_i && (virt_ptr(tgt_nxt) != 2'h3) && (vp != 2'h3);
            tpb_r <= pb;
         end
         // a write that lands on a pointer byte stores the value bare, so no modify
         if (ind_req && do_upd && !(req_write_i && pb != 3'h7))
            ptr_r[vp] <= upd;
         if (state_r == IPA_ACCESS && we_r && tpb_r != 3'h7 && !tgt_virt_r)
         begin
            // written value lands over the addressed byte of the pair without a modify
            if (tpb_r[0])
               ptr_r[tpb_r[2:1]][15:8] <= wd_r;
            else
               ptr_r[tpb_r[2:1]][7:0] <= wd_r;
         end
      end
   end

   // ==================================================
   // memory side and answer
   // ==================================================
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mem_req_o <= 1'b0;
         mem_we_o <= 1'b0;
         mem_addr_o <= '0;
         mem_wdata_o <= '0;
      end
      else
      begin
         // other special registers pass through with their own side effects
         mem_req_o <= req_i && state_r == IPA_IDLE && !(!req_direct_i &&
            vp != 2'h3 && virt_ptr(tgt_nxt) != 2'h3) && pb == 3'h7;
         mem_we_o <= req_write_i;
         mem_addr_o <= tgt_nxt;
         mem_wdata_o <= req_wdata_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         done_o <= 1'b0;
         rdata_o <= '0;
      end
      else
      begin
         done_o <= state_r == IPA_ACCESS;
         if (state_r == IPA_ACCESS)
         begin
            if (tgt_virt_r)
               rdata_o <= READ_ZERO;
            else if (tpb_r != 3'h7)
               rdata_o <= tpb_r[0] ? ptr_r[tpb_r[2:1]][15:8] : ptr_r[tpb_r[2:1]][7:0];
            else
               rdata_o <= mem_rdata_i;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ptr0_o <= PTR_RESET;
         ptr1_o <= PTR_RESET;
         ptr2_o <= PTR_RESET;
      end
      else
      begin
         ptr0_o <= ptr_r[0];
         ptr1_o <= ptr_r[1];
         ptr2_o <= ptr_r[2];
      end
   end
endmodule : ipa_indirect_unit
`default_nettype wire

// ---- ipa_unit_monitor.sv ----
// concurrent checks on the ports of the indirect pointer addressing unit
`timescale 1ns/1ps
`default_nettype none
module ipa_monitor
   import ipa_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic extended_set_enable_bit_i,
   input wire logic req_i,
   input wire logic req_write_i,
   input wire logic req_direct_i,
   input wire logic req_access_bank_i,
   input wire logic [ADDR_W-1:0] req_addr_i,
   input wire logic [DATA_W-1:0] acc_i,
   input wire logic mem_req_o,
   input wire logic [ADDR_W-1:0] mem_addr_o,
   input wire logic done_o,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic [PTR_W-1:0] ptr0_o,
   input wire logic [PTR_W-1:0] ptr2_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========
   // request tracking
   logic take_r;
   logic tk;
   logic ind;
   logic qb;
   // a request in the cycle after one was taken is refused
   assign tk = req_i & ~take_r;
   assign ind = tk & ~req_direct_i;
   assign qb = tk & req_direct_i & req_access_bank_i;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         take_r <= 1'b0;
      else
         take_r <= tk;
   end
   // ==========
   // properties
   property p_answer; tk |-> ##1 !done_o ##1 done_o; endproperty
   a_answer: assert property (p_answer) else $error("done late");
   property p_done; done_o |=> !done_o; endproperty
   a_done: assert property (p_done) else $error("done too long");
   property p_mem; mem_req_o |=> done_o && !mem_req_o; endproperty
   a_mem: assert property (p_mem) else $error("mem pulse wrong");
   property p_accumulator_offset_access; ind && req_addr_i == VIRT_BASE_0 |-> ##2
      (!$past(mem_req_o) || $past(mem_addr_o) == ptr0_o[11:0] + $past(acc_i, 2))
      ##1 $stable(ptr0_o); endproperty
   a_accumulator_offset_access: assert property (p_accumulator_offset_access) else $error("offset access wrong");
   property p_vrd; ind && !req_write_i && req_addr_i == VIRT_BASE_0 + 12'h004 |-> ##2
      (ptr0_o != 16'h0FE7 || (!$past(mem_req_o) && rdata_o == READ_ZERO)); endproperty
   a_vrd: assert property (p_vrd) else $error("virtual read not zero");
   property p_vwr; ind && req_write_i && req_addr_i == VIRT_BASE_0 + 12'h004 |-> ##2
      (ptr0_o != 16'h0FE7 || !$past(mem_req_o)); endproperty
   a_vwr: assert property (p_vwr) else $error("virtual write reached memory");
   property p_quick; qb && extended_set_enable_bit_i && req_addr_i[7:0] <= OFFSET_LIMIT
      |-> ##2 $past(mem_addr_o) == ptr2_o[11:0] + $past(req_addr_i[7:0], 2); endproperty
   a_quick: assert property (p_quick) else $error("indexed offset wrong");
   property p_high; qb && req_addr_i[7:0] >= QUICK_SPLIT && req_addr_i[7:0] < 8'hD9
      |-> ##1 mem_req_o && mem_addr_o == {4'hF, $past(req_addr_i[7:0])}; endproperty
   a_high: assert property (p_high) else $error("high quick bank wrong");
   property p_post_increment_access; ind && !req_write_i && req_addr_i == VIRT_BASE_0 + 12'h002
      |-> ##2 ptr0_o == $past(ptr0_o) + PTR_ONE; endproperty
   a_post_increment_access: assert property (p_post_increment_access) else $error("post increment carry wrong");
   property p_selfwr; ind && req_write_i && req_addr_i == VIRT_BASE_2 + 12'h003 |-> ##2
      ($past(mem_addr_o) != PTR_BASE_2 + 12'h001 || ptr2_o[7:0] == $past(ptr2_o[7:0]));
      endproperty
   a_selfwr: assert property (p_selfwr) else $error("pointer write was modified");
endmodule : ipa_monitor
bind ipa_indirect_unit ipa_monitor ipa_monitor_inst
(
   .clk_i(clk_i),
   .rst_i(rst_i),
   .extended_set_enable_bit_i(extended_set_enable_bit_i),
   .req_i(req_i),
   .req_write_i(req_write_i),
   .req_direct_i(req_direct_i),
   .req_access_bank_i(req_access_bank_i),
   .req_addr_i(req_addr_i),
   .acc_i(acc_i),
   .mem_req_o(mem_req_o),
   .mem_addr_o(mem_addr_o),
   .done_o(done_o),
   .rdata_o(rdata_o),
   .ptr0_o(ptr0_o),
   .ptr2_o(ptr2_o)
);
`default_nettype wire

// ---- ipa_tb_top.sv ----
// self-checking bench of the indirect pointer addressing unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ipa_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic extended_set_enable_bit_i = 1'b0;
   logic req_i = 1'b0;
   logic req_write_i = 1'b0;
   logic req_direct_i = 1'b0;
   logic req_access_bank_i = 1'b0;
   logic [11:0] req_addr_i = 12'h000;
   logic [7:0] req_wdata_i = 8'h00;
   logic [7:0] acc_i = 8'h00;
   logic [7:0] mem_rdata_i = 8'h00;
   logic mem_req_o;
   logic mem_we_o;
   logic [11:0] mem_addr_o;
   logic [7:0] mem_wdata_o;
   logic done_o;
   logic [7:0] rdata_o;
   logic [15:0] ptr0_o;
   logic [15:0] ptr1_o;
   logic [15:0] ptr2_o;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   ipa_indirect_unit ipa_indirect_unit_inst
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .extended_set_enable_bit_i(extended_set_enable_bit_i),
      .req_i(req_i),
      .req_write_i(req_write_i),
      .req_direct_i(req_direct_i),
      .req_access_bank_i(req_access_bank_i),
      .req_addr_i(req_addr_i),
      .req_wdata_i(req_wdata_i),
      .acc_i(acc_i),
      .mem_req_o(mem_req_o),
      .mem_we_o(mem_we_o),
      .mem_addr_o(mem_addr_o),
      .mem_wdata_o(mem_wdata_o),
      .mem_rdata_i(mem_rdata_i),
      .done_o(done_o),
      .rdata_o(rdata_o),
      .ptr0_o(ptr0_o),
      .ptr1_o(ptr1_o),
      .ptr2_o(ptr2_o)
   );
   always #5 clk_i = ~clk_i;
   // ==========
   // shared tasks
   task automatic tally_and_finish;
      if (fail_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : chk
   // one request, started and ended at a falling edge
   task automatic op(input logic w, input logic d, input logic b, input logic [11:0] a,
      input logic [7:0] wd, input logic em, input logic [11:0] ea, input logic [7:0] er);
      req_write_i = w;
      req_direct_i = d;
      req_access_bank_i = b;
      req_addr_i = a;
      req_wdata_i = wd;
      req_i = 1'b1;
      @(negedge clk_i);
      req_i = 1'b0;
      // with no memory access er is the expected answer and memory shows its inverse
      mem_rdata_i = em ? er : ~er;
      chk(mem_req_o === em && (!em || (mem_addr_o === ea && mem_we_o === w &&
         (!w || mem_wdata_o === wd))), "memory access");
      @(negedge clk_i);
      // stale data after the sampling edge must not be mistaken for an answer
      mem_rdata_i = ~er;
      chk(done_o === 1'b1 && (w || rdata_o === er), "answer");
      @(negedge clk_i);
   endtask : op
   task automatic wp(input logic [11:0] base, input logic [15:0] v);
      op(1'b1, 1'b1, 1'b0, base, v[7:0], 1'b0, 12'h000, 8'h00);
      op(1'b1, 1'b1, 1'b0, base + 12'h001, v[15:8], 1'b0, 12'h000, 8'h00);
   endtask : wp
   // ==========
   // scenarios
   task automatic t_modes;
      wp(PTR_BASE_0, 16'h00FF);
      chk(ptr0_o === 16'h00FF, "pointer write");
      op(1'b0, 1'b0, 1'b0, VIRT_BASE_0 + 12'h002, 8'h00, 1'b1, 12'h0FF, 8'h5A);
      chk(ptr0_o === 16'h0100, "carry");
      op(1'b0, 1'b0, 1'b0, VIRT_BASE_0 + 12'h001, 8'h00, 1'b1, 12'h101, 8'hC3);
      op(1'b1, 1'b0, 1'b0, VIRT_BASE_0 + 12'h003, 8'h11, 1'b1, 12'h101, 8'h00);
      op(1'b0, 1'b0, 1'b0, VIRT_BASE_0 + 12'h003, 8'h00, 1'b1, 12'h100, 8'h3C);
      chk(ptr0_o === 16'h00FF, "borrow");
      acc_i = 8'h10;
      op(1'b0, 1'b0, 1'b0, VIRT_BASE_0, 8'h00, 1'b1, 12'h10F, 8'h96);
      chk(ptr0_o === 16'h00FF, "offset kept pointer");
   endtask : t_modes
   task automatic t_virt;
      wp(PTR_BASE_1, 16'h0123);
      wp(PTR_BASE_0, 16'h0FE7);
      op(1'b0, 1'b0, 1'b0, VIRT_BASE_0 + 12'h004, 8'h00, 1'b0, 12'h000, 8'h00);
      op(1'b1, 1'b0, 1'b0, VIRT_BASE_0 + 12'h004, 8'h77, 1'b0, 12'h000, 8'h00);
      chk(ptr1_o === 16'h0123, "virtual write");
      wp(PTR_BASE_0, 16'h0FC1);
      op(1'b0, 1'b0, 1'b0, VIRT_BASE_0 + 12'h004, 8'h00, 1'b1, 12'hFC1, 8'h81);
   endtask : t_virt
   task automatic t_self;
      wp(PTR_BASE_2, 16'h0FD9);
      op(1'b0, 1'b1, 1'b0, PTR_BASE_2 + 12'h001, 8'h00, 1'b0, 12'h000, 8'h0F);
      op(1'b1, 1'b0, 1'b0, VIRT_BASE_2 + 12'h003, 8'h44, 1'b0, 12'h000, 8'h00);
      chk(ptr2_o === 16'h0F44, "self write");
      wp(PTR_BASE_2, 16'h0FDA);
      op(1'b1, 1'b0, 1'b0, VIRT_BASE_2 + 12'h003, 8'h03, 1'b0, 12'h000, 8'h00);
      chk(ptr2_o === 16'h03DA, "self write high byte");
   endtask : t_self
   task automatic t_ext;
      wp(PTR_BASE_2, 16'h0200);
      op(1'b0, 1'b1, 1'b1, 12'h005, 8'h00, 1'b1, 12'h005, 8'h21);
      extended_set_enable_bit_i = 1'b1;
      op(1'b0, 1'b1, 1'b1, 12'h005, 8'h00, 1'b1, 12'h205, 8'h22);
      op(1'b1, 1'b1, 1'b1, 12'h05F, 8'h09, 1'b1, 12'h25F, 8'h00);
      op(1'b0, 1'b1, 1'b1, 12'h060, 8'h00, 1'b1, 12'hF60, 8'h23);
      op(1'b0, 1'b1, 1'b0, 12'h105, 8'h00, 1'b1, 12'h105, 8'h24);
      wp(PTR_BASE_0, 16'h0010);
      op(1'b0, 1'b0, 1'b0, VIRT_BASE_0 + 12'h002, 8'h00, 1'b1, 12'h010, 8'h25);
      chk(ptr0_o === 16'h0011, "extended pointer");
   endtask : t_ext
   // ==========
   // main sequence and watchdog
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fail_count++;
         tally_and_finish;
      end
   end
   initial
   begin
      repeat (3) @(negedge clk_i);
      rst_i = 1'b0;
      chk(ptr0_o === PTR_RESET && done_o === 1'b0, "reset");
      t_modes;
      t_virt;
      t_self;
      t_ext;
      tally_and_finish;
   end
endmodule : tb_top
`default_nettype wire
